// [dmac_debug_cmd.sv]
`timescale 1ns/1ps
`include "dmac_defines.svh"
module dmac_debug_cmd
   import dmac_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // receive bytes from debug_line
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   // transmit bytes to debug_line
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // device state
   input  wire logic        debug_mode_bit,
   input  wire logic        read_protect,
   input  wire logic        flash_unlocked,
   input  wire logic [7:0]  exec_len,
   output logic             fetch_stop,
   // memory access port
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [1:0]       mem_space,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic        mem_rvalid,
   input  wire logic [7:0]  mem_rdata,
   // execute port
   output logic             exec_valid,
   output logic [7:0]       exec_byte
);
   // ************************************************************
   // command state
   // ************************************************************
   dmac_state_t state_q, state_d;
   logic [7:0]  op_q, op_d;
   logic [15:0] addr_q, addr_d;
   logic [16:0] cnt_q, cnt_d;
   logic [2:0]  xcnt_q, xcnt_d;
   logic        allow_q, allow_d;
   logic        rd_q, rd_d, wr_q, wr_d, xv_q, xv_d;
   logic [7:0]  wd_q, wd_d, rdat_q, rdat_d;
   logic [1:0]  sp_q, sp_d;
   logic        fs_q;
   logic        push, buf_ready, take, allow;
   logic [7:0]  exec_n;
   assign allow  = debug_mode_bit && !read_protect;
   assign take   = rx_valid && rx_ready;
   assign push   = (state_q == DMAC_RD_PUSH);
   assign exec_n = (exec_len == 8'h00) ? 8'h01 :
                   (exec_len > 8'h05) ? 8'h05 : exec_len;

   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      addr_d  = addr_q;
      cnt_d   = cnt_q;
      xcnt_d  = xcnt_q;
      allow_d = allow_q;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      xv_d    = 1'b0;
      wd_d    = wd_q;
      rdat_d  = rdat_q;
      sp_d    = sp_q;
      case (state_q)
         DMAC_IDLE: begin
            if (take) begin
               op_d    = rx_data;
               allow_d = allow;
               case (rx_data)
                  `DMAC_OP_RD_REG, `DMAC_OP_WR_PMEM,
                  `DMAC_OP_RD_PMEM, `DMAC_OP_WR_DMEM: begin
                     state_d = DMAC_ADDR_HI;
                  end
                  `DMAC_OP_EXEC: begin
                     state_d = DMAC_EXEC;
                     xcnt_d  = allow ? exec_n[2:0] : 3'h1;
                  end
                  default: state_d = DMAC_IDLE;
               endcase
            end
         end
         DMAC_ADDR_HI: if (take) begin
            addr_d[15:8] = (op_q == `DMAC_OP_RD_REG) ?
                           {4'h0, rx_data[3:0]} : rx_data;
            state_d = DMAC_ADDR_LO;
         end
         DMAC_ADDR_LO: if (take) begin
            addr_d[7:0] = rx_data;
            state_d = (op_q == `DMAC_OP_RD_REG) ? DMAC_SIZE_LO :
                      DMAC_SIZE_HI;
         end
         DMAC_SIZE_HI: if (take) begin
            cnt_d   = {1'b0, rx_data, 8'h00};
            state_d = DMAC_SIZE_LO;
         end
         DMAC_SIZE_LO: if (take) begin
            cnt_d = {cnt_q[16:8], rx_data};
            if (op_q == `DMAC_OP_RD_REG) begin
               cnt_d = {9'h000, rx_data};
               if (rx_data == 8'h00)
                  cnt_d = `DMAC_SIZE_256;
            end else if ({cnt_q[15:8], rx_data} == 16'h0000) begin
               cnt_d = `DMAC_SIZE_65536;
            end
            sp_d    = (op_q == `DMAC_OP_RD_REG)  ? 2'h0 :
                      (op_q == `DMAC_OP_WR_DMEM) ? 2'h2 : 2'h1;
            state_d = (op_q == `DMAC_OP_RD_REG ||
                       op_q == `DMAC_OP_RD_PMEM) ?
                      DMAC_RD_REQ : DMAC_WR_DATA;
         end
         DMAC_RD_REQ: begin
            if (allow_q) begin
               rd_d    = 1'b1;
               state_d = DMAC_RD_WAIT;
            end else begin
               rdat_d  = `DMAC_BLANK_BYTE;
               state_d = DMAC_RD_PUSH;
            end
         end
         DMAC_RD_WAIT: if (mem_rvalid) begin
            rdat_d  = mem_rdata;
            state_d = DMAC_RD_PUSH;
         end
         DMAC_RD_PUSH: if (buf_ready) begin
            addr_d  = addr_q + 16'h0001;
            cnt_d   = cnt_q - 17'h0_0001;
            state_d = (cnt_q == 17'h0_0001) ? DMAC_IDLE
                      : DMAC_RD_REQ;
         end
         DMAC_WR_DATA: if (take) begin
            wd_d = rx_data;
            wr_d = allow_q && (op_q != `DMAC_OP_WR_PMEM ||
                   flash_unlocked);
            addr_d  = addr_q + 16'h0001;
            cnt_d   = cnt_q - 17'h0_0001;
            if (cnt_q == 17'h0_0001)
               state_d = DMAC_IDLE;
         end
         DMAC_EXEC: if (take) begin
            wd_d   = rx_data;
            xv_d   = allow_q;
            xcnt_d = xcnt_q - 3'h1;
            if (xcnt_q == 3'h1)
               state_d = DMAC_IDLE;
         end
         default: state_d = DMAC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= DMAC_IDLE;
         op_q    <= 8'h00;
         addr_q  <= 16'h0000;
         cnt_q   <= `DMAC_SIZE_ZERO;
         xcnt_q  <= 3'h0;
         allow_q <= 1'b0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         xv_q    <= 1'b0;
         wd_q    <= 8'h00;
         rdat_q  <= 8'h00;
         sp_q    <= 2'h0;
         fs_q    <= 1'b0;
         rx_ready <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         addr_q  <= addr_d;
         cnt_q   <= cnt_d;
         xcnt_q  <= xcnt_d;
         allow_q <= allow_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
         xv_q    <= xv_d;
         wd_q    <= wd_d;
         rdat_q  <= rdat_d;
         sp_q    <= sp_d;
         fs_q    <= debug_mode_bit;
         rx_ready <= !(state_d inside {DMAC_RD_REQ, DMAC_RD_WAIT,
                                       DMAC_RD_PUSH});
      end
   end
   // write address is the pre-increment one, read address the current one
   logic [15:0] ma_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         ma_q <= 16'h0000;
      else
         ma_q <= wr_d ? addr_q : addr_d;
   end
   assign fetch_stop = fs_q;
   assign mem_rd     = rd_q;
   assign mem_wr     = wr_q;
   assign mem_space  = sp_q;
   assign mem_addr   = ma_q;
   assign mem_wdata  = wd_q;
   assign exec_valid = xv_q;
   assign exec_byte  = wd_q;
   // ************************************************************
   // two-entry transmit buffer
   // ************************************************************
   logic [7:0] b0_q, b0_d, b1_q, b1_d;
   logic [1:0] n_q, n_d;
   logic       pop, tv_q;
   assign buf_ready = (n_q != 2'h2);
   assign pop       = tv_q && tx_ready;
   always_comb begin
      b0_d = b0_q;
      b1_d = b1_q;
      n_d  = n_q;
      if (pop) begin
         b0_d = b1_q;
         n_d  = n_d - 2'h1;
      end
      if (push && buf_ready) begin
         if (n_d == 2'h0)
            b0_d = rdat_q;
         else
            b1_d = rdat_q;
         n_d = n_d + 2'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         b0_q     <= 8'h00;
         b1_q     <= 8'h00;
         n_q      <= 2'h0;
         tv_q     <= 1'b0;
      end else begin
         b0_q     <= b0_d;
         b1_q     <= b1_d;
         n_q      <= n_d;
         tv_q     <= (n_d != 2'h0);
      end
   end
   assign tx_valid = tv_q;
   assign tx_data  = b0_q;

   // ************************************************************
   // checks
   // ************************************************************
   a_blank_read: assert property (@(posedge mclk) disable iff (rst)
      (state_q == DMAC_RD_REQ && !allow_q) |=> rdat_q == 8'hFF)
      else $error("blocked read did not yield FFh");
   a_reg_size: assert property (@(posedge mclk) disable iff (rst)
      (state_q == DMAC_SIZE_LO && take && op_q == 8'h09
       && rx_data == 8'h00) |=> cnt_q == 17'h0_0100)
      else $error("register read size zero not 256");
   a_pmem_size: assert property (@(posedge mclk) disable iff (rst)
      (state_q == DMAC_SIZE_LO && take && op_q == 8'h0B
       && cnt_q[15:8] == 8'h00 && rx_data == 8'h00)
      |=> cnt_q == 17'h1_0000)
      else $error("program read size zero not 65536");
   a_write_gate: assert property (@(posedge mclk) disable iff (rst)
      mem_wr |-> $past(allow_q))
      else $error("write issued outside debug");
   a_flash_gate: assert property (@(posedge mclk) disable iff (rst)
      (mem_wr && mem_space == 2'h1) |-> $past(flash_unlocked))
      else $error("program write while flash locked");
   a_no_opcode: assert property (@(posedge mclk) disable iff (rst)
      (state_q inside {DMAC_RD_REQ, DMAC_RD_WAIT, DMAC_RD_PUSH})
      |-> !rx_ready)
      else $error("byte accepted during read reply");
   a_addr_mask: assert property (@(posedge mclk) disable iff (rst)
      (state_q == DMAC_ADDR_HI && take && op_q == 8'h09)
      |=> addr_q[15:12] == 4'h0)
      else $error("register address upper bits nonzero");
   a_exec_gate: assert property (@(posedge mclk) disable iff (rst)
      exec_valid |-> $past(allow_q))
      else $error("execute byte outside debug");
   c_reg_read: cover property (@(posedge mclk) disable iff (rst)
      state_q == DMAC_RD_PUSH && op_q == 8'h09);
   c_pmem_write: cover property (@(posedge mclk) disable iff (rst)
      mem_wr && mem_space == 2'h1);
   c_buf_full: cover property (@(posedge mclk) disable iff (rst)
      n_q == 2'h2);
endmodule : dmac_debug_cmd

// [dmac_defines.svh]
`ifndef DMAC_DEFINES_SVH
`define DMAC_DEFINES_SVH
// ************************************************************
// command opcodes
// ************************************************************
`define DMAC_OP_RD_REG    8'h09
`define DMAC_OP_WR_PMEM   8'h0A
`define DMAC_OP_RD_PMEM   8'h0B
`define DMAC_OP_WR_DMEM   8'h0C
`define DMAC_OP_EXEC      8'h12
// ************************************************************
// values
// ************************************************************
`define DMAC_BLANK_BYTE   8'hFF
`define DMAC_SIZE_ZERO    17'h0_0000
`define DMAC_SIZE_256     17'h0_0100
`define DMAC_SIZE_65536   17'h1_0000
`define DMAC_EXEC_MAX     3'h5
`define DMAC_BUF_DEPTH    2
`endif

// [dmac_host_model.sv]
`timescale 1ns/1ps
// ************************************************************
// debug host: collects reply bytes, stalls at random
// ************************************************************
module dmac_host_model (
   // clock
   input  wire logic       mclk,
   // reply stream from the decoder
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready
);
   integer     seed = 32'h2a9310e3;
   logic [7:0] got_q[$];
   initial tx_ready = 1'b0;
   always @(negedge mclk) begin
      tx_ready <= ($random(seed) % 3) != 0;
   end
   // take reply bytes in order
   always @(posedge mclk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         got_q.push_back(tx_data);
      end
   end
endmodule : dmac_host_model

// [dmac_pkg.sv]
package dmac_pkg;
   typedef enum logic [3:0] {
      DMAC_IDLE    = 4'b0000,
      DMAC_ADDR_HI = 4'b0001,
      DMAC_ADDR_LO = 4'b0010,
      DMAC_SIZE_HI = 4'b0011,
      DMAC_SIZE_LO = 4'b0100,
      DMAC_RD_REQ  = 4'b0101,
      DMAC_RD_WAIT = 4'b0110,
      DMAC_RD_PUSH = 4'b0111,
      DMAC_WR_DATA = 4'b1000,
      DMAC_EXEC    = 4'b1001
   } dmac_state_t;
endpackage : dmac_pkg

// [test_debug_memory_access_commands.sv]
`timescale 1ns/1ps
module test_debug_memory_access_commands;
   logic mclk = 1'b0, rst, rx_valid, rx_ready, tx_valid, tx_ready;
   logic debug_mode_bit, read_protect, flash_unlocked, fetch_stop;
   logic mem_rd, mem_wr, mem_rvalid, exec_valid;
   logic [7:0] rx_data, tx_data, exec_len, mem_wdata, mem_rdata, exec_byte;
   logic [1:0] mem_space, cur_space;
   logic [15:0] mem_addr, ra;
   logic [25:0] wr_q[$];
   logic [7:0] ex_q[$];
   integer seed = 32'h2a9310e3, err_count = 0, num_checks = 0, j;
   always #50 mclk = ~mclk;
   dmac_debug_cmd u_dmac_debug_cmd (.mclk(mclk), .rst(rst),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .debug_mode_bit(debug_mode_bit), .read_protect(read_protect),
      .flash_unlocked(flash_unlocked), .exec_len(exec_len),
      .fetch_stop(fetch_stop), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .exec_valid(exec_valid), .exec_byte(exec_byte));
   dmac_host_model u_dmac_host_model (.mclk(mclk), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));
   // ************************************************************
   // reference model and checks
   // ************************************************************
   function automatic logic [7:0] mv(input logic [1:0] s,
                                     input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ {s, 6'h15};
   endfunction : mv
   task chk(input string what, input logic [25:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task wrap_up;
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   always begin
      @(posedge mclk);
      if (mem_rd === 1'b1) begin
         ra = mem_addr;
         chk("read space", cur_space, mem_space);
         repeat ($random(seed) & 3) @(posedge mclk);
         @(negedge mclk); mem_rvalid = 1'b1; mem_rdata = mv(cur_space, ra);
         @(negedge mclk); mem_rvalid = 1'b0; mem_rdata = ~mem_rdata;
      end
   end
   always @(posedge mclk) begin
      if (mem_wr === 1'b1) begin
         chk("write", wr_q.size() ? wr_q.pop_front() : '1,
             {mem_space, mem_addr, mem_wdata});
      end
      if (exec_valid === 1'b1)
         chk("exec", ex_q.size() ? ex_q.pop_front() : 'x, exec_byte);
   end
   // ************************************************************
   // host byte driver and command sequencer
   // ************************************************************
   task send(input logic [7:0] b);
      integer k;
      @(negedge mclk); rx_valid = 1'b1; rx_data = b;
      k = 0;
      do begin @(posedge mclk); k++; end while (rx_ready !== 1'b1 && k < 3000);
      if (k >= 3000) chk("rx_ready", 1, 0);
   endtask : send
   task cmd(input logic [7:0] op, input logic [15:0] a, input logic [16:0] n,
            input logic dbg, prot, fl, input logic [7:0] el);
      logic ok;
      logic [16:0] cnt;
      logic [7:0] b;
      integer i, k;
      @(negedge mclk); debug_mode_bit = dbg; read_protect = prot;
      flash_unlocked = fl; exec_len = el;
      ok = dbg && !prot;
      cnt = (n != 0) ? n : (op == 8'h09) ? 17'd256 : 17'h1_0000;
      cur_space = (op == 8'h09) ? 2'd0 : (op == 8'h0C) ? 2'd2 : 2'd1;
      send(op);
      if (op == 8'h12) begin
         cnt = !ok || el == 0 ? 1 : (el > 5) ? 5 : el;
         for (i = 0; i < cnt; i++) begin
            b = $random(seed);
            if (ok) ex_q.push_back(b);
            send(b);
         end
      end else if (op != 8'h55) begin
         send(op == 8'h09 ? {4'h0, a[11:8]} : a[15:8]);
         send(a[7:0]);
         if (op != 8'h09) send(n[15:8]);
         send(n[7:0]);
         for (i = 0; op[0] == 1'b0 && i < cnt; i++) begin
            b = $random(seed);
            if (ok && (op == 8'h0C || fl))
               wr_q.push_back({cur_space, a + i[15:0], b});
            send(b);
         end
      end
      @(negedge mclk); rx_valid = 1'b0; rx_data = ~rx_data;
      if (op == 8'h09 || op == 8'h0B) begin
         k = 0;
         while (u_dmac_host_model.got_q.size() < cnt && k < 20000) begin
            @(posedge mclk); k++;
         end
         for (i = 0; i < cnt; i++) begin
            b = u_dmac_host_model.got_q.size() ?
                u_dmac_host_model.got_q.pop_front() : 'x;
            chk("reply", ok ? mv(cur_space, a + i[15:0]) : 8'hFF, b);
         end
      end
      repeat (4) @(posedge mclk);
      chk("writes left", 0, wr_q.size());
      chk("exec left", 0, ex_q.size());
   endtask : cmd
   initial begin
      rst = 1'b1; rx_valid = 1'b0; rx_data = 8'h00; exec_len = 8'h00;
      debug_mode_bit = 1'b0; read_protect = 1'b0; flash_unlocked = 1'b0;
      mem_rvalid = 1'b0; mem_rdata = 8'h00; cur_space = 2'd0;
      repeat (2) @(posedge mclk);
      @(negedge mclk) rst = 1'b0;
      cmd(8'h09, 16'h0E80, 3, 1, 0, 0, 0);
      cmd(8'h09, 16'h0E80, 0, 1, 0, 0, 0);
      cmd(8'h09, 16'h0123, 2, 0, 0, 1, 0);
      cmd(8'h09, 16'h0123, 4, 1, 1, 1, 0);
      cmd(8'h0A, 16'h1234, 3, 1, 0, 1, 0);
      cmd(8'h0A, 16'h1234, 3, 1, 0, 0, 0);
      cmd(8'h0A, 16'h2000, 2, 1, 1, 1, 0);
      cmd(8'h0C, 16'h2000, 2, 0, 0, 1, 0);
      cmd(8'h0C, 16'hABCD, 4, 1, 0, 0, 0);
      cmd(8'h0B, 16'hFFFE, 4, 1, 0, 0, 0);
      cmd(8'h0B, 16'h0200, 3, 1, 1, 0, 0);
      cmd(8'h0B, 16'h0300, 3, 0, 0, 0, 0);
      cmd(8'h55, 16'h0000, 1, 1, 0, 0, 0);
      cmd(8'h12, 16'h0000, 1, 1, 0, 0, 3);
      cmd(8'h12, 16'h0000, 1, 1, 0, 0, 0);
      cmd(8'h12, 16'h0000, 1, 1, 0, 0, 7);
      cmd(8'h12, 16'h0000, 1, 0, 0, 0, 4);
      for (j = 0; j < 8; j++)
         cmd(j[0] ? 8'h0B : 8'h0A, 16'($random(seed)),
             17'(($random(seed) & 7) + 1), j[1], j[2], 1'b1, 0);
      @(negedge mclk) debug_mode_bit = 1'b1;
      repeat (2) @(negedge mclk);
      chk("fetch_stop", 1, fetch_stop);
      debug_mode_bit = 1'b0;
      repeat (2) @(negedge mclk);
      chk("fetch_stop", 0, fetch_stop);
      wrap_up();
   end
   initial begin
      repeat (50000) @(posedge mclk);
      err_count++;
      wrap_up();
   end
endmodule : test_debug_memory_access_commands
